// ---- rtl/bdpc_cfg.svh ----
// Purpose: Constants of the bulk DMA port control register bank.
// Assumes: Bit numbers are hardware positions, 0 being the least significant.
// Notes: Software field numbers count from the MSB; position = 31 - field number.
`ifndef BDPC_CFG_SVH
`define BDPC_CFG_SVH

`define BDPC_AW 8
`define BDPC_CTRL_OFS 8'h94
`define BDPC_STAT_OFS 8'h9c
`define BDPC_CTRL_RST 32'h16800121
`define BDPC_CTRL_WMASK 32'h1fdfffff
`define BDPC_RXSB_LSB 26
`define BDPC_TXSB_LSB 23
`define BDPC_SB_W 3
`define BDPC_BACK_POL 22
`define BDPC_AACK_POL 20
`define BDPC_IBSY_POL 19
`define BDPC_OAV_POL 18
`define BDPC_OEN_POL 17
`define BDPC_IEN_POL 16
`define BDPC_LE_BIT 15
`define BDPC_PAD_BIT 14
`define BDPC_DLY_LSB 10
`define BDPC_DLY_W 4
`define BDPC_OMODE_LSB 8
`define BDPC_OMODE_W 2
`define BDPC_BURST_BIT 7
`define BDPC_IMODE_LSB 4
`define BDPC_IMODE_W 3
`define BDPC_RXPAD_BIT 3
`define BDPC_ORST_BIT 2
`define BDPC_IRST_BIT 1
`define BDPC_TRIS_BIT 0
`define BDPC_STAT_OAV 14

`endif

// ---- rtl/bdpc_pkg.sv ----
// Purpose: Types of the bulk DMA port control register bank.
// Assumes: Nothing beyond the standard language.
// Notes: Constants live in bdpc_cfg.svh.
package bdpc_pkg;

    typedef struct packed {
        logic [31:0] ctrl;
        logic [31:0] rdata;
        logic [3:0] pins;
        logic [15:0] bus_data;
        logic [1:0] bus_oe_n;
        logic bus_req;
        logic [15:0] rx_word;
        logic [31:0] rx_quad;
        logic rx_valid;
        logic [2:0] rx_keep;
        logic [31:0] tx_quad;
        logic tx_valid;
        logic tx_align;
    } bdpc_state_t;

endpackage : bdpc_pkg

// ---- rtl/bdpc_top.sv ----
// Purpose: Control register and pin shaping of the bulk DMA data port.
// Assumes: All inputs are synchronous to clock_in; bus_reset_in is a pulse.
// Notes: Pins in the four-pin group are registered, so they lag one cycle.
//
// Chosen here: strobed register access.
`timescale 1ns/1ns
`include "bdpc_cfg.svh"

module bdpc_top (
    // Clock and resets
    input wire logic clock_in,
    input wire logic reset_in,
    input wire logic bus_reset_in,
    // Register port
    input wire logic [`BDPC_AW-1:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [31:0] rdata_out,
    // Configuration levels and port-logic reset pulses
    output logic [2:0] rx_status_buf_size_out,
    output logic [2:0] tx_status_buf_size_out,
    output logic little_endian_sel_out,
    output logic auto_zero_pad_out,
    output logic [3:0] in_delay_field_out,
    output logic [1:0] out_port_mode_out,
    output logic burst_mode_out,
    output logic [2:0] in_port_mode_out,
    output logic rx_pad_allow_out,
    output logic out_logic_reset_out,
    output logic in_logic_reset_out,
    // Handshake pins
    input wire logic bulk_ack_act_in,
    input wire logic async_ack_act_in,
    input wire logic in_busy_act_in,
    input wire logic out_avail_act_in,
    output logic bulk_ack_pin_out,
    output logic async_ack_pin_out,
    output logic in_busy_pin_out,
    output logic out_avail_pin_out,
    input wire logic out_enable_pin_in,
    input wire logic in_enable_pin_in,
    output logic out_enable_act_out,
    output logic in_enable_act_out,
    // Bulk data bus
    input wire logic [15:0] tx_word_in,
    input wire logic tx_drive_in,
    input wire logic bulk_request_in,
    input wire logic [15:0] bulk_data_bus_in,
    output logic [15:0] bulk_data_bus_out,
    output logic [1:0] bulk_data_bus_oe_n_out,
    output logic bulk_request_pin_out,
    output logic [15:0] rx_word_out,
    // Receive quadlet path
    input wire logic [31:0] rx_quad_in,
    input wire logic [1:0] rx_bytes_in,
    input wire logic rx_last_in,
    input wire logic rx_valid_in,
    output logic [31:0] rx_quad_out,
    output logic rx_valid_out,
    output logic [2:0] rx_keep_bytes_out,
    // Transmit quadlet path
    input wire logic [31:0] tx_quad_in,
    input wire logic [1:0] tx_bytes_in,
    input wire logic tx_last_in,
    input wire logic tx_valid_in,
    output logic [31:0] tx_quad_out,
    output logic tx_valid_out,
    output logic tx_align_req_out
);

    bdpc_pkg::bdpc_state_t s_q;
    bdpc_pkg::bdpc_state_t s_d;
    logic wr_ctrl;
    logic [3:0] act_out;
    logic [3:0] pol_out;

    // Byte lanes kept for a last quadlet of n bytes; 0 means all four.
    function automatic logic [31:0] keep_mask(input logic [1:0] n);
        logic [31:0] m;
        m = 32'hffffffff;
        case (n)
            2'h1: m = 32'hff000000;
            2'h2: m = 32'hffff0000;
            2'h3: m = 32'hffffff00;
            default: m = 32'hffffffff;
        endcase
        return m;
    endfunction : keep_mask

    function automatic logic [15:0] order(input logic le, input logic [15:0] w);
        return le ? {w[7:0], w[15:8]} : w;
    endfunction : order

    assign wr_ctrl = wr_in && (addr_in == `BDPC_CTRL_OFS);
    assign act_out = {bulk_ack_act_in, async_ack_act_in, in_busy_act_in, out_avail_act_in};
    assign pol_out = {s_q.ctrl[`BDPC_BACK_POL], s_q.ctrl[`BDPC_AACK_POL],
                      s_q.ctrl[`BDPC_IBSY_POL], s_q.ctrl[`BDPC_OAV_POL]};

    always_comb begin
        s_d = s_q;
        // The two port-logic reset bits live for a single cycle only.
        s_d.ctrl[`BDPC_ORST_BIT] = 1'b0;
        s_d.ctrl[`BDPC_IRST_BIT] = 1'b0;
        if (wr_ctrl) begin
            s_d.ctrl = wdata_in & `BDPC_CTRL_WMASK;
        end
        // Bus reset clears only the reset bits, and it beats a same-cycle write.
        if (bus_reset_in) begin
            s_d.ctrl[`BDPC_ORST_BIT] = 1'b0;
            s_d.ctrl[`BDPC_IRST_BIT] = 1'b0;
        end
        s_d.rdata = 32'h0;
        if (rd_in && addr_in == `BDPC_CTRL_OFS) begin
            s_d.rdata = s_q.ctrl;
        end else if (rd_in && addr_in == `BDPC_STAT_OFS) begin
            s_d.rdata[`BDPC_STAT_OAV] = out_avail_act_in;
        end
        s_d.pins = act_out ^ ~pol_out;
        s_d.bus_data = order(s_q.ctrl[`BDPC_LE_BIT], tx_word_in);
        // The upper byte floats on the tri-state bit, the request pin does not.
        s_d.bus_oe_n[1] = !tx_drive_in || s_q.ctrl[`BDPC_TRIS_BIT];
        s_d.bus_oe_n[0] = !tx_drive_in;
        s_d.bus_req = bulk_request_in;
        s_d.rx_word = order(s_q.ctrl[`BDPC_LE_BIT], bulk_data_bus_in);
        s_d.rx_valid = rx_valid_in;
        s_d.rx_quad = rx_quad_in;
        s_d.rx_keep = 3'h4;
        if (rx_valid_in && rx_last_in) begin
            s_d.rx_quad = rx_quad_in & keep_mask(rx_bytes_in);
            // Without pad permission the pad bytes are not counted as data.
            if (!s_q.ctrl[`BDPC_RXPAD_BIT] && rx_bytes_in != 2'h0) begin
                s_d.rx_keep = {1'b0, rx_bytes_in};
            end
        end
        s_d.tx_valid = tx_valid_in;
        s_d.tx_quad = tx_quad_in;
        s_d.tx_align = 1'b0;
        if (tx_valid_in && tx_last_in && tx_bytes_in != 2'h0) begin
            if (s_q.ctrl[`BDPC_PAD_BIT]) begin
                s_d.tx_quad = tx_quad_in & keep_mask(tx_bytes_in);
            end else begin
                s_d.tx_align = 1'b1;
            end
        end
    end

    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            s_q <= '0;
            s_q.ctrl <= `BDPC_CTRL_RST;
            s_q.pins <= 4'hf;
            s_q.bus_oe_n <= 2'h3;
            s_q.rx_keep <= 3'h4;
        end else begin
            s_q <= s_d;
        end
    end

    assign rdata_out = s_q.rdata;
    assign rx_status_buf_size_out = s_q.ctrl[`BDPC_RXSB_LSB +: `BDPC_SB_W];
    assign tx_status_buf_size_out = s_q.ctrl[`BDPC_TXSB_LSB +: `BDPC_SB_W];
    assign little_endian_sel_out = s_q.ctrl[`BDPC_LE_BIT];
    assign auto_zero_pad_out = s_q.ctrl[`BDPC_PAD_BIT];
    // Stored as written; only zero is a meaningful setting.
    assign in_delay_field_out = s_q.ctrl[`BDPC_DLY_LSB +: `BDPC_DLY_W];
    assign out_port_mode_out = s_q.ctrl[`BDPC_OMODE_LSB +: `BDPC_OMODE_W];
    assign burst_mode_out = s_q.ctrl[`BDPC_BURST_BIT];
    assign in_port_mode_out = s_q.ctrl[`BDPC_IMODE_LSB +: `BDPC_IMODE_W];
    assign rx_pad_allow_out = s_q.ctrl[`BDPC_RXPAD_BIT];
    assign out_logic_reset_out = s_q.ctrl[`BDPC_ORST_BIT];
    assign in_logic_reset_out = s_q.ctrl[`BDPC_IRST_BIT];
    assign {bulk_ack_pin_out, async_ack_pin_out, in_busy_pin_out, out_avail_pin_out} = s_q.pins;
    // Enable pins arrive from the host; turned to active high without delay.
    assign out_enable_act_out = ~(out_enable_pin_in ^ s_q.ctrl[`BDPC_OEN_POL]);
    assign in_enable_act_out = ~(in_enable_pin_in ^ s_q.ctrl[`BDPC_IEN_POL]);
    assign bulk_data_bus_out = s_q.bus_data;
    assign bulk_data_bus_oe_n_out = s_q.bus_oe_n;
    assign bulk_request_pin_out = s_q.bus_req;
    assign rx_word_out = s_q.rx_word;
    assign rx_quad_out = s_q.rx_quad;
    assign rx_valid_out = s_q.rx_valid;
    assign rx_keep_bytes_out = s_q.rx_keep;
    assign tx_quad_out = s_q.tx_quad;
    assign tx_valid_out = s_q.tx_valid;
    assign tx_align_req_out = s_q.tx_align;

    AST_RX_SIZE: assert property (@(posedge clock_in) disable iff (reset_in)
        wr_ctrl |=> rx_status_buf_size_out == $past(wdata_in[28:26]))
        else $error("receive status size not taken from write");

    AST_TX_SIZE_KEPT: assert property (@(posedge clock_in) disable iff (reset_in)
        (bus_reset_in && !wr_ctrl) |=> $stable(tx_status_buf_size_out))
        else $error("bus reset changed transmit status size");

    AST_PIN_POL: assert property (@(posedge clock_in) disable iff (reset_in)
        ##1 bulk_ack_pin_out == $past(bulk_ack_act_in ^ ~s_q.ctrl[22]))
        else $error("bulk ack pin polarity wrong");

    AST_LE_SWAP: assert property (@(posedge clock_in) disable iff (reset_in)
        little_endian_sel_out |=> bulk_data_bus_out == {$past(tx_word_in[7:0]),
        $past(tx_word_in[15:8])})
        else $error("little-endian byte swap missing");

    AST_TX_PAD: assert property (@(posedge clock_in) disable iff (reset_in)
        (tx_valid_in && tx_last_in && tx_bytes_in == 2'h1 && auto_zero_pad_out)
        |=> tx_quad_out[23:0] == 24'h0 && !tx_align_req_out)
        else $error("transmit tail not zero-padded");

    AST_MODES_KEPT: assert property (@(posedge clock_in) disable iff (reset_in)
        (bus_reset_in && !wr_ctrl) |=> $stable(out_port_mode_out) && $stable(in_port_mode_out))
        else $error("bus reset changed a port mode");

    AST_RX_FILL: assert property (@(posedge clock_in) disable iff (reset_in)
        (rx_valid_in && rx_last_in && rx_bytes_in == 2'h2) |=> rx_quad_out[15:0] == 16'h0)
        else $error("received tail not zero-filled");

    AST_OUT_RST: assert property (@(posedge clock_in) disable iff (reset_in)
        (wr_ctrl && wdata_in[2] && !bus_reset_in) |=> out_logic_reset_out
        ##1 (out_logic_reset_out == $past(wr_ctrl && wdata_in[2] && !bus_reset_in)))
        else $error("output-logic reset not a single pulse");

    AST_BUS_RST: assert property (@(posedge clock_in) disable iff (reset_in)
        bus_reset_in |=> !out_logic_reset_out && !in_logic_reset_out)
        else $error("bus reset left a port-logic reset set");

    AST_TRIS: assert property (@(posedge clock_in) disable iff (reset_in)
        s_q.ctrl[0] |=> bulk_data_bus_oe_n_out[1] && bulk_request_pin_out == $past(bulk_request_in))
        else $error("upper data byte driven while tri-stated");

    AST_AVAIL_FLAG: assert property (@(posedge clock_in) disable iff (reset_in)
        (rd_in && addr_in == 8'h9c) |=> rdata_out == {17'h0, $past(out_avail_act_in), 14'h0})
        else $error("output-available flag not raw");

    AST_IN_RST: assert property (@(posedge clock_in) disable iff (reset_in)
        (wr_ctrl && wdata_in[1] && !bus_reset_in) |=> in_logic_reset_out
        ##1 (in_logic_reset_out == $past(wr_ctrl && wdata_in[1] && !bus_reset_in)))
        else $error("input-logic reset not a single pulse");

    AST_RST_NEEDS_WRITE: assert property (@(posedge clock_in) disable iff (reset_in)
        !wr_ctrl |=> !out_logic_reset_out && !in_logic_reset_out)
        else $error("port-logic reset high without a write");

    AST_TX_SIZE: assert property (@(posedge clock_in) disable iff (reset_in)
        wr_ctrl |=> tx_status_buf_size_out == $past(wdata_in[25:23]))
        else $error("transmit status size not taken from write");

    AST_RX_SIZE_KEPT: assert property (@(posedge clock_in) disable iff (reset_in)
        (bus_reset_in && !wr_ctrl) |=> $stable(rx_status_buf_size_out))
        else $error("bus reset changed receive status size");

    AST_MODES_WRITE: assert property (@(posedge clock_in) disable iff (reset_in)
        wr_ctrl |=> out_port_mode_out == $past(wdata_in[9:8])
        && in_port_mode_out == $past(wdata_in[6:4]))
        else $error("port mode not taken from write");

    AST_BURST: assert property (@(posedge clock_in) disable iff (reset_in)
        wr_ctrl |=> burst_mode_out == $past(wdata_in[7]))
        else $error("burst bit not taken from write");

    AST_CTRL_KEPT: assert property (@(posedge clock_in) disable iff (reset_in)
        (bus_reset_in && !wr_ctrl) |=> $stable(s_q.ctrl[31:3]) && $stable(s_q.ctrl[0]))
        else $error("bus reset changed a kept control bit");

    AST_BE_PASS: assert property (@(posedge clock_in) disable iff (reset_in)
        !little_endian_sel_out |=> bulk_data_bus_out == $past(tx_word_in))
        else $error("big-endian word not passed straight");

    AST_TX_ALIGN: assert property (@(posedge clock_in) disable iff (reset_in)
        (tx_valid_in && tx_last_in && tx_bytes_in != 2'h0 && !auto_zero_pad_out)
        |=> tx_align_req_out && tx_quad_out == $past(tx_quad_in))
        else $error("unpadded transmit tail not handed to alignment");

    AST_RX_KEEP: assert property (@(posedge clock_in) disable iff (reset_in)
        (rx_valid_in && rx_last_in && rx_bytes_in != 2'h0 && !rx_pad_allow_out)
        |=> rx_keep_bytes_out == {1'b0, $past(rx_bytes_in)})
        else $error("pad bytes counted without permission");

    AST_RX_KEEP_ALL: assert property (@(posedge clock_in) disable iff (reset_in)
        rx_pad_allow_out |=> rx_keep_bytes_out == 3'h4)
        else $error("pad bytes stripped although allowed");

    AST_LOW_DRIVE: assert property (@(posedge clock_in) disable iff (reset_in)
        tx_drive_in |=> !bulk_data_bus_oe_n_out[0])
        else $error("lower data byte not driven");

    AST_UPPER_DRIVE: assert property (@(posedge clock_in) disable iff (reset_in)
        (tx_drive_in && !s_q.ctrl[0]) |=> !bulk_data_bus_oe_n_out[1])
        else $error("upper data byte not driven");

    AST_AVAIL_POL: assert property (@(posedge clock_in) disable iff (reset_in)
        ##1 out_avail_pin_out == $past(out_avail_act_in ^ ~s_q.ctrl[18]))
        else $error("output-available pin polarity wrong");

endmodule : bdpc_top

// ---- test/bdpc_host_model.sv ----
// Purpose: Host DMA side of the bulk data bus.
// Assumes: The host drives its bytes only when asked to.
// Notes: A byte that nobody drives toggles every cycle, so a stale value never passes.
`timescale 1ns/1ns

module bdpc_host_model (
    // Clock
    input wire logic clock_in,
    // Device side of the bus
    input wire logic [15:0] dev_data_in,
    input wire logic [1:0] dev_oe_n_in,
    // Host side of the bus
    input wire logic host_drive_in,
    input wire logic [15:0] host_word_in,
    output logic [15:0] wire_out
);
    logic [15:0] float_q = 16'h00ff;

    always @(posedge clock_in) begin
        float_q <= ~float_q;
    end

    always_comb begin
        for (int b = 0; b < 2; b++) begin
            wire_out[8*b+:8] = !dev_oe_n_in[b] ? dev_data_in[8*b+:8] :
                host_drive_in ? host_word_in[8*b+:8] : float_q[8*b+:8];
        end
    end
endmodule : bdpc_host_model

// ---- test/bdpc_top_tb.sv ----
// Purpose: Self-checking bench of the bulk DMA port control bank.
// Assumes: Register port strobes last one cycle; outputs settle 1 ns after the edge.
// Notes: Two configurations are run; the second leaves the upper byte driven.
`timescale 1ns/1ns
`include "bdpc_cfg.svh"

module bdpc_top_tb;
    logic clock_in, reset_in, bus_reset_in, wr_in, rd_in, little_endian_sel_out;
    logic auto_zero_pad_out, burst_mode_out, rx_pad_allow_out, out_logic_reset_out;
    logic in_logic_reset_out, bulk_ack_act_in, async_ack_act_in, in_busy_act_in;
    logic out_avail_act_in, bulk_ack_pin_out, async_ack_pin_out, in_busy_pin_out;
    logic out_avail_pin_out, out_enable_pin_in, in_enable_pin_in, out_enable_act_out;
    logic in_enable_act_out, tx_drive_in, bulk_request_in, bulk_request_pin_out, rx_last_in;
    logic rx_valid_in, rx_valid_out, tx_last_in, tx_valid_in, tx_valid_out, tx_align_req_out;
    logic host_drive;
    logic [1:0] out_port_mode_out, bulk_data_bus_oe_n_out, rx_bytes_in, tx_bytes_in;
    logic [2:0] rx_status_buf_size_out, tx_status_buf_size_out, in_port_mode_out;
    logic [2:0] rx_keep_bytes_out;
    logic [3:0] in_delay_field_out;
    logic [7:0] addr_in;
    logic [15:0] tx_word_in, bulk_data_bus_in, bulk_data_bus_out, rx_word_out, host_word;
    logic [31:0] wdata_in, rdata_out, rx_quad_in, rx_quad_out, tx_quad_in, tx_quad_out;
    // The input delay field is zero in both settings.
    // Status buffers take 12 and 16 quadlets, leaving the rest of the shared RAM free.
    logic [31:0] cfg [2] = '{32'h14800121, 32'h0b4fc2d8};
    int n_errors = 0;
    int cmp_count = 0;
    int cyc = 0;

    bdpc_top i_dut (.clock_in, .reset_in, .bus_reset_in, .addr_in, .wdata_in, .wr_in, .rd_in,
        .rdata_out, .rx_status_buf_size_out, .tx_status_buf_size_out, .little_endian_sel_out,
        .auto_zero_pad_out, .in_delay_field_out, .out_port_mode_out, .burst_mode_out,
        .in_port_mode_out, .rx_pad_allow_out, .out_logic_reset_out, .in_logic_reset_out,
        .bulk_ack_act_in, .async_ack_act_in, .in_busy_act_in, .out_avail_act_in,
        .bulk_ack_pin_out, .async_ack_pin_out, .in_busy_pin_out, .out_avail_pin_out,
        .out_enable_pin_in, .in_enable_pin_in, .out_enable_act_out, .in_enable_act_out,
        .tx_word_in, .tx_drive_in, .bulk_request_in, .bulk_data_bus_in, .bulk_data_bus_out,
        .bulk_data_bus_oe_n_out, .bulk_request_pin_out, .rx_word_out, .rx_quad_in,
        .rx_bytes_in, .rx_last_in, .rx_valid_in, .rx_quad_out, .rx_valid_out,
        .rx_keep_bytes_out, .tx_quad_in, .tx_bytes_in, .tx_last_in, .tx_valid_in,
        .tx_quad_out, .tx_valid_out, .tx_align_req_out);

    bdpc_host_model i_host (.clock_in, .dev_data_in(bulk_data_bus_out),
        .dev_oe_n_in(bulk_data_bus_oe_n_out), .host_drive_in(host_drive),
        .host_word_in(host_word), .wire_out(bulk_data_bus_in));

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : stop_test

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clock_in);
        wr_in <= 1'b0;
        #1;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clock_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clock_in);
        rd_in <= 1'b0;
        #1 d = rdata_out;
    endtask : rd

    initial begin
        clock_in = 1'b0;
        forever #25 clock_in = ~clock_in;
    end

    // A hang costs a mismatch instead of a silent stall.
    always @(posedge clock_in) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            n_errors++;
            stop_test();
        end
    end

    initial begin
        logic [31:0] c, v;
        logic a;
        {addr_in, wdata_in, wr_in, rd_in, bus_reset_in, bulk_ack_act_in, async_ack_act_in,
            in_busy_act_in, out_avail_act_in, out_enable_pin_in, in_enable_pin_in, tx_word_in,
            tx_drive_in, bulk_request_in, rx_quad_in, rx_bytes_in, rx_last_in, rx_valid_in,
            tx_quad_in, tx_bytes_in, tx_last_in, tx_valid_in, host_drive, host_word} = '0;
        reset_in = 1'b1;
        repeat (8) @(posedge clock_in);
        reset_in <= 1'b0;
        rd(`BDPC_CTRL_OFS, v);
        chk("ctrl reset", v, 32'h16800121);
        chk("pins reset", {bulk_ack_pin_out, in_busy_pin_out, bulk_data_bus_oe_n_out}, 4'hf);
        foreach (cfg[i]) begin
            c = cfg[i];
            wr(`BDPC_CTRL_OFS, c);
            wr(`BDPC_CTRL_OFS, c | 32'h00000006);
            chk("port resets", {out_logic_reset_out, in_logic_reset_out}, 2'b11);
            rd(`BDPC_CTRL_OFS, v);
            chk("resets cleared", {out_logic_reset_out, in_logic_reset_out}, 2'b00);
            chk("ctrl", v & 32'h1fdffff9, c);
            chk("fields", {rx_status_buf_size_out, tx_status_buf_size_out, little_endian_sel_out,
                auto_zero_pad_out, in_delay_field_out, out_port_mode_out, burst_mode_out,
                in_port_mode_out, rx_pad_allow_out}, {c[28:23], c[15:3]});
            for (int k = 0; k < 2; k++) begin
                a = k[0];
                @(posedge clock_in);
                {bulk_ack_act_in, async_ack_act_in, in_busy_act_in, out_avail_act_in} <= {4{a}};
                out_enable_pin_in <= a;
                in_enable_pin_in <= !a;
                @(posedge clock_in);
                #1 chk("pins", {bulk_ack_pin_out, async_ack_pin_out, in_busy_pin_out,
                    out_avail_pin_out},
                    {a ^ !c[22], a ^ !c[20], a ^ !c[19], a ^ !c[18]});
                chk("enables", {out_enable_act_out, in_enable_act_out},
                    {!(a ^ c[17]), !(!a ^ c[16])});
                rd(`BDPC_STAT_OFS, v);
                chk("status", v, {17'h0, a, 14'h0});
            end
            @(posedge clock_in);
            tx_word_in <= 16'h1234;
            tx_drive_in <= 1'b1;
            bulk_request_in <= 1'b1;
            host_drive <= 1'b1;
            host_word <= 16'h5566;
            {rx_quad_in, tx_quad_in} <= {2{32'haabbccdd}};
            {rx_bytes_in, tx_bytes_in} <= 4'h9;
            {rx_last_in, rx_valid_in, tx_last_in, tx_valid_in} <= 4'hf;
            @(posedge clock_in);
            tx_drive_in <= 1'b0;
            bulk_request_in <= 1'b0;
            {rx_last_in, rx_valid_in, tx_last_in, tx_valid_in} <= 4'h0;
            #1 chk("bus word", bulk_data_bus_out, c[15] ? 16'h3412 : 16'h1234);
            chk("bus oe_n", bulk_data_bus_oe_n_out, {c[0], 1'b0});
            chk("request", bulk_request_pin_out, 1'b1);
            chk("rx quad", rx_quad_out, 32'haabb0000);
            chk("valids", {rx_valid_out, tx_valid_out}, 2'b11);
            chk("rx keep", rx_keep_bytes_out, c[3] ? 3'h4 : 3'h2);
            chk("tx quad", tx_quad_out, c[14] ? 32'haa000000 : 32'haabbccdd);
            chk("tx align", tx_align_req_out, !c[14]);
            repeat (2) @(posedge clock_in);
            #1 chk("rx word", rx_word_out, c[15] ? 16'h6655 : 16'h5566);
            chk("bus released", bulk_data_bus_oe_n_out, 2'b11);
            chk("request low", bulk_request_pin_out, 1'b0);
            chk("valids idle", {rx_valid_out, tx_valid_out, tx_align_req_out}, 3'h0);
        end
        wr(`BDPC_CTRL_OFS, c | 32'h00000004);
        chk("out reset only", {out_logic_reset_out, in_logic_reset_out}, 2'b10);
        wr(`BDPC_CTRL_OFS, c | 32'h00000002);
        chk("in reset only", {out_logic_reset_out, in_logic_reset_out}, 2'b01);
        @(posedge clock_in);
        addr_in <= `BDPC_CTRL_OFS;
        wdata_in <= c | 32'h00000006;
        wr_in <= 1'b1;
        bus_reset_in <= 1'b1;
        @(posedge clock_in);
        wr_in <= 1'b0;
        bus_reset_in <= 1'b0;
        #1 chk("bus reset wins", {out_logic_reset_out, in_logic_reset_out}, 2'b00);
        @(posedge clock_in);
        bus_reset_in <= 1'b1;
        @(posedge clock_in);
        bus_reset_in <= 1'b0;
        wr(8'h40, 32'hffffffff);
        rd(8'h40, v);
        chk("unmapped", v, 32'h0);
        rd(`BDPC_CTRL_OFS, v);
        chk("ctrl kept", v & 32'h1fdffff9, c);
        stop_test();
    end
endmodule : bdpc_top_tb
